// [betu_pkg.sv]
/*
  betu_pkg: constants, types and register map of the bus event trigger unit.
  assumes an axi4-lite master on the same clock.
*/
package betu_pkg;
  localparam int unsigned NUM_DET = 4;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned EXT_W = 4;
  localparam int unsigned NUM_SRC = 9;
  localparam logic [15:0] DATA_VALID_LIMIT = 16'hfdff;
  localparam int unsigned CHK_PAUSE_CYCLES = 8;
  localparam int unsigned CLK_RST_CYCLES = 16;
  // byte offsets, per detector stride 0x20
  localparam logic [7:0] OFF_DET_BASE = 8'h00;
  localparam logic [7:0] DET_STRIDE = 8'h20;
  localparam logic [7:0] OFF_DET_A0 = 8'h00;
  localparam logic [7:0] OFF_DET_A1 = 8'h04;
  localparam logic [7:0] OFF_DET_DATA = 8'h08;
  localparam logic [7:0] OFF_DET_STAT = 8'h0c;
  localparam logic [7:0] OFF_DET_EXT = 8'h10;
  localparam logic [7:0] OFF_EXEC_BASE = 8'h80;
  localparam logic [7:0] OFF_LEVEL = 8'h90;
  localparam logic [7:0] OFF_TRIG_SEL = 8'h94;
  localparam logic [7:0] OFF_CHK_SEL = 8'h98;
  localparam logic [7:0] OFF_CLK_SEL = 8'h9c;
  localparam logic [7:0] OFF_STATUS = 8'ha0;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    ST_ANY = 4'h0, ST_OPFETCH = 4'h1, ST_RW = 4'h2, ST_RD = 4'h3, ST_WR = 4'h4,
    ST_PRW = 4'h5, ST_PRD = 4'h6, ST_PWR = 4'h7, ST_MRW = 4'h8, ST_MRD = 4'h9, ST_MWR = 4'ha
  } betu_status_e;

  typedef enum logic [1:0] {CAP_REG = 2'h0, CAP_SFR = 2'h1, CAP_RAM = 2'h2} betu_cap_e;

  typedef struct packed {
    logic valid;
    logic [15:0] addr;
    logic [15:0] data;
    logic fetch;
    logic write;
    logic macro;
  } betu_cycle_s;

  typedef struct packed {
    logic en;
    logic [15:0] val;
    logic [15:0] care;
  } betu_pat16_s;

  typedef struct packed {
    betu_pat16_s a0;
    betu_pat16_s a1;
    logic den;
    logic [7:0] dval;
    logic [7:0] dcare;
    logic [3:0] stat;
    logic een;
    logic [3:0] eval;
    logic [3:0] ecare;
  } betu_det_s;

  localparam logic [3:0] CHK_IDLE = 4'h1;
  localparam logic [3:0] CHK_PAUSE = 4'h2;
  localparam logic [3:0] CHK_CAPT = 4'h4;
  localparam logic [3:0] CHK_RESUME = 4'h8;
endpackage : betu_pkg

// [betu_bus_event_trigger_unit.sv]
/*
  betu_bus_event_trigger_unit: bus event, execution-address and level detectors,
  trigger or, checkpoint sequencer and clock select with cpu reset.
  assumes cpu bus cycles and execute strobe on clk; sense pins are asynchronous.
*/
// Register access over AXI4-Lite and the register addresses are this design's own decisions.
// Function
// - four bus event detectors, each with own address, data, status, external terms
// - bus event fires only when all four comparisons match together
// - two exact 16-bit address patterns (care always written as ffff), either one matching suffices
// - no address pattern set means address always matches
// - 8-bit masked data pattern on low byte, valid up to fdff
// - no data pattern set means data always matches
// - eleven status classes: fetch, rw, r, w, program and macro variants, any
// - no status class set means status always matches
// - 4-bit masked external pattern on sense inputs five to eight
// - no external pattern set means external always matches
// - level detector fires when sense inputs one to four match pattern
// - trigger is or of selected sources among nine detectors
// - trigger selection off means trigger never asserts
// - four execution detectors fire when instruction at their address executes
// - checkpoint pauses cpu, captures regs, sfrs or ram, then resumes
// - capture goes into the next trace frame; bus events may lag
// - cleared checkpoint selection stops all pauses, and every capture except one whose count ends in the first cycle it is cleared
// - selecting cpu clock source also resets the cpu
`timescale 1ns/1ps
module betu_bus_event_trigger_unit (
  input wire logic clk,
  input wire logic arst_n,
  input wire betu_pkg::betu_cycle_s cpuCycle,
  input wire logic execValid,
  input wire logic [15:0] execAddr,
  input wire logic [7:0] senseIn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic trigOut,
  output logic [8:0] eventOut,
  output logic cpuPause,
  output logic captureStrobe,
  output logic [1:0] captureKind,
  output logic cpuReset,
  output logic clkSelUser
);
  typedef struct packed {
    betu_pkg::betu_det_s [3:0] det;
    logic [3:0][15:0] execA;
    logic [3:0] execEn;
    logic [3:0] lvl;
    logic [8:0] trigSel;
    logic [8:0] chkSel;
    logic [1:0] capKind;
    logic clkUser;
    logic [7:0] sync1;
    logic [7:0] sync2;
    logic [8:0] evt;
    logic trig;
    logic [3:0] chkState;
    logic [7:0] chkCnt;
    logic capStb;
    logic pause;
    logic awRdy;
    logic wRdy;
    logic arRdy;
    logic [7:0] rstCnt;
    logic cpuRst;
    logic awHave;
    logic [7:0] awAddr;
    logic wHave;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
  } betu_state_s;

  betu_state_s st_ff;
  betu_state_s nxt_st;

  function automatic logic pat16Hit(input betu_pkg::betu_pat16_s p, input logic [15:0] v);
    pat16Hit = p.en && (((v ^ p.val) & p.care) == 16'h0000);
  endfunction : pat16Hit

  function automatic logic statHit(input logic [3:0] s, input betu_pkg::betu_cycle_s c);
    logic rw;
    rw = !c.fetch;
    unique case (s)
      betu_pkg::ST_ANY: statHit = 1'b1;
      betu_pkg::ST_OPFETCH: statHit = c.fetch;
      betu_pkg::ST_RW: statHit = rw;
      betu_pkg::ST_RD: statHit = rw && !c.write;
      betu_pkg::ST_WR: statHit = rw && c.write;
      betu_pkg::ST_PRW: statHit = rw && !c.macro;
      betu_pkg::ST_PRD: statHit = rw && !c.macro && !c.write;
      betu_pkg::ST_PWR: statHit = rw && !c.macro && c.write;
      betu_pkg::ST_MRW: statHit = rw && c.macro;
      betu_pkg::ST_MRD: statHit = rw && c.macro && !c.write;
      betu_pkg::ST_MWR: statHit = rw && c.macro && c.write;
      default: statHit = 1'b0;
    endcase
  endfunction : statHit

  function automatic logic [31:0] readReg(input betu_state_s s, input logic [7:0] a);
    logic [2:0] d;
    readReg = 32'h00000000;
    d = a[7:5];
    if (a < betu_pkg::OFF_EXEC_BASE)
    begin
      unique case (a[4:0])
        betu_pkg::OFF_DET_A0[4:0]: readReg = {s.det[d[1:0]].a0.en, 15'h0000, s.det[d[1:0]].a0.val};
        betu_pkg::OFF_DET_A1[4:0]: readReg = {s.det[d[1:0]].a1.en, 15'h0000, s.det[d[1:0]].a1.val};
        betu_pkg::OFF_DET_DATA[4:0]: readReg = {s.det[d[1:0]].den, 15'h0000, s.det[d[1:0]].dcare,
          s.det[d[1:0]].dval};
        betu_pkg::OFF_DET_STAT[4:0]: readReg = {28'h0000000, s.det[d[1:0]].stat};
        betu_pkg::OFF_DET_EXT[4:0]: readReg = {s.det[d[1:0]].een, 23'h000000, s.det[d[1:0]].ecare,
          s.det[d[1:0]].eval};
        default: readReg = 32'h00000000;
      endcase
    end
    else if (a < betu_pkg::OFF_LEVEL)
      readReg = {s.execEn[a[3:2]], 15'h0000, s.execA[a[3:2]]};
    else if (a == betu_pkg::OFF_LEVEL)
      readReg = {28'h0000000, s.lvl};
    else if (a == betu_pkg::OFF_TRIG_SEL)
      readReg = {23'h000000, s.trigSel};
    else if (a == betu_pkg::OFF_CHK_SEL)
      readReg = {21'h000000, s.capKind, s.chkSel};
    else if (a == betu_pkg::OFF_CLK_SEL)
      readReg = {31'h00000000, s.clkUser};
    else if (a == betu_pkg::OFF_STATUS)
      readReg = {14'h0000, s.cpuRst, s.chkState, s.trig, 3'h0, s.evt};
  endfunction : readReg

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'h0) && ((a < betu_pkg::OFF_EXEC_BASE) ? (a[4:0] <= betu_pkg::OFF_DET_EXT[4:0])
      : (a <= betu_pkg::OFF_STATUS));
  endfunction : mapped

  always_comb
  begin
    logic [8:0] hit;
    logic [31:0] wd;
    logic [7:0] wa;
    logic [1:0] di;
    logic dataOk;
    hit = 9'h000;
    wd = 32'h00000000;
    wa = 8'h00;
    di = 2'h0;
    dataOk = 1'b0;
    nxt_st = st_ff;
    nxt_st.sync1 = senseIn;
    nxt_st.sync2 = st_ff.sync1;
    for (int i = 0; i < 4; i++)
    begin
      dataOk = !st_ff.det[i].den
        || ((cpuCycle.addr <= betu_pkg::DATA_VALID_LIMIT)
        && (((cpuCycle.data[7:0] ^ st_ff.det[i].dval) & st_ff.det[i].dcare) == 8'h00));
      hit[i] = cpuCycle.valid
        && ((!st_ff.det[i].a0.en && !st_ff.det[i].a1.en)
        || pat16Hit(st_ff.det[i].a0, cpuCycle.addr) || pat16Hit(st_ff.det[i].a1, cpuCycle.addr))
        && dataOk
        && statHit(st_ff.det[i].stat, cpuCycle)
        && (!st_ff.det[i].een
        || (((st_ff.sync2[7:4] ^ st_ff.det[i].eval) & st_ff.det[i].ecare) == 4'h0));
      hit[5 + i] = execValid && st_ff.execEn[i] && (execAddr == st_ff.execA[i]);
    end
    // level compare, stays high for as long as it holds
    hit[4] = (st_ff.sync2[3:0] == st_ff.lvl);
    nxt_st.evt = hit;
    nxt_st.trig = |(hit & st_ff.trigSel);
    // checkpoint sequencer
    nxt_st.capStb = 1'b0;
    unique case (st_ff.chkState)
      betu_pkg::CHK_IDLE:
        if (|(hit & st_ff.chkSel))
        begin
          nxt_st.chkState = betu_pkg::CHK_PAUSE;
          nxt_st.chkCnt = 8'h00;
        end
      betu_pkg::CHK_PAUSE:
        nxt_st.chkState = betu_pkg::CHK_CAPT;
      betu_pkg::CHK_CAPT:
      begin
        nxt_st.chkCnt = st_ff.chkCnt + 8'h01;
        if (st_ff.chkCnt == 8'(betu_pkg::CHK_PAUSE_CYCLES - 1))
        begin
          nxt_st.capStb = 1'b1;
          nxt_st.chkState = betu_pkg::CHK_RESUME;
        end
      end
      betu_pkg::CHK_RESUME:
        nxt_st.chkState = betu_pkg::CHK_IDLE;
      default:
        nxt_st.chkState = betu_pkg::CHK_IDLE;
    endcase
    if (st_ff.chkSel == 9'h000)
      nxt_st.chkState = betu_pkg::CHK_IDLE;
    // cpu reset countdown
    if (st_ff.rstCnt != 8'h00)
      nxt_st.rstCnt = st_ff.rstCnt - 8'h01;
    nxt_st.cpuRst = (nxt_st.rstCnt != 8'h00);
    // axi write path
    if (s_axi_awvalid && !st_ff.awHave)
    begin
      nxt_st.awHave = 1'b1;
      nxt_st.awAddr = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid && !st_ff.wHave)
    begin
      nxt_st.wHave = 1'b1;
      nxt_st.wData = s_axi_wdata;
      nxt_st.wStrb = s_axi_wstrb;
    end
    if (st_ff.awHave && st_ff.wHave && !st_ff.bValid)
    begin
      wa = st_ff.awAddr;
      wd = st_ff.wData;
      di = wa[6:5];
      nxt_st.awHave = 1'b0;
      nxt_st.wHave = 1'b0;
      nxt_st.bValid = 1'b1;
      if (mapped(wa) && (wa != betu_pkg::OFF_STATUS))
        nxt_st.bResp = betu_pkg::AXI_OKAY;
      else
        nxt_st.bResp = betu_pkg::AXI_SLVERR;
      if (mapped(wa) && (st_ff.wStrb == 4'hf))
      begin
        if (wa < betu_pkg::OFF_EXEC_BASE)
        begin
          unique case (wa[4:0])
            betu_pkg::OFF_DET_A0[4:0]:
            begin
              nxt_st.det[di].a0.en = wd[31];
              nxt_st.det[di].a0.val = wd[15:0];
              nxt_st.det[di].a0.care = 16'hffff;
            end
            betu_pkg::OFF_DET_A1[4:0]:
            begin
              nxt_st.det[di].a1.en = wd[31];
              nxt_st.det[di].a1.val = wd[15:0];
              nxt_st.det[di].a1.care = 16'hffff;
            end
            betu_pkg::OFF_DET_DATA[4:0]:
            begin
              nxt_st.det[di].den = wd[31];
              nxt_st.det[di].dval = wd[7:0];
              nxt_st.det[di].dcare = wd[15:8];
            end
            betu_pkg::OFF_DET_STAT[4:0]: nxt_st.det[di].stat = wd[3:0];
            betu_pkg::OFF_DET_EXT[4:0]:
            begin
              nxt_st.det[di].een = wd[31];
              nxt_st.det[di].eval = wd[3:0];
              nxt_st.det[di].ecare = wd[7:4];
            end
            default: nxt_st.det[di].stat = st_ff.det[di].stat;
          endcase
        end
        else if (wa < betu_pkg::OFF_LEVEL)
        begin
          nxt_st.execEn[wa[3:2]] = wd[31];
          nxt_st.execA[wa[3:2]] = wd[15:0];
        end
        else if (wa == betu_pkg::OFF_LEVEL)
          nxt_st.lvl = wd[3:0];
        else if (wa == betu_pkg::OFF_TRIG_SEL)
          nxt_st.trigSel = wd[8:0];
        else if (wa == betu_pkg::OFF_CHK_SEL)
        begin
          nxt_st.chkSel = wd[8:0];
          nxt_st.capKind = wd[10:9];
        end
        else if (wa == betu_pkg::OFF_CLK_SEL)
        begin
          nxt_st.clkUser = wd[0];
          nxt_st.rstCnt = 8'(betu_pkg::CLK_RST_CYCLES);
          nxt_st.cpuRst = 1'b1;
        end
      end
    end
    if (st_ff.bValid && s_axi_bready)
      nxt_st.bValid = 1'b0;
    // axi read path
    if (s_axi_arvalid && !st_ff.rValid)
    begin
      nxt_st.rValid = 1'b1;
      nxt_st.rData = mapped(s_axi_araddr[7:0]) ? readReg(st_ff, s_axi_araddr[7:0]) : 32'h00000000;
      nxt_st.rResp = mapped(s_axi_araddr[7:0]) ? betu_pkg::AXI_OKAY : betu_pkg::AXI_SLVERR;
    end
    else if (st_ff.rValid && s_axi_rready)
      nxt_st.rValid = 1'b0;
    // registered flags so outputs leave flip-flops directly
    nxt_st.awRdy = !nxt_st.awHave;
    nxt_st.wRdy = !nxt_st.wHave;
    nxt_st.arRdy = !nxt_st.rValid;
    nxt_st.pause = (nxt_st.chkState != betu_pkg::CHK_IDLE);
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_ff <= '0;
      st_ff.chkState <= betu_pkg::CHK_IDLE;
      st_ff.awRdy <= 1'b1;
      st_ff.wRdy <= 1'b1;
      st_ff.arRdy <= 1'b1;
    end
    else
      st_ff <= nxt_st;
  end

  assign s_axi_awready = st_ff.awRdy;
  assign s_axi_wready = st_ff.wRdy;
  assign s_axi_bvalid = st_ff.bValid;
  assign s_axi_bresp = st_ff.bResp;
  assign s_axi_arready = st_ff.arRdy;
  assign s_axi_rvalid = st_ff.rValid;
  assign s_axi_rdata = st_ff.rData;
  assign s_axi_rresp = st_ff.rResp;
  assign trigOut = st_ff.trig;
  assign eventOut = st_ff.evt;
  assign cpuPause = st_ff.pause;
  assign captureStrobe = st_ff.capStb;
  assign captureKind = st_ff.capKind;
  assign cpuReset = st_ff.cpuRst;
  assign clkSelUser = st_ff.clkUser;
endmodule : betu_bus_event_trigger_unit

// [betu_checker.sv]
/*
  betu_checker: timing relations of the trigger unit outputs.
  bound to the unit; sees its ports only.
*/
`timescale 1ns/1ps
module betu_checker (
  input wire logic clk,
  input wire logic arst_n,
  input wire betu_pkg::betu_cycle_s cpuCycle,
  input wire logic execValid,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic trigOut,
  input wire logic [8:0] eventOut,
  input wire logic cpuPause,
  input wire logic captureStrobe,
  input wire logic cpuReset
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  a_bus_evt_cause: assert property (|eventOut[3:0] |-> $past(cpuCycle.valid)) else $error("bus event no cycle");
  a_exec_evt_cause: assert property (|eventOut[8:5] |-> $past(execValid)) else $error("exec event no exec");
  a_trig_has_source: assert property (trigOut |-> |eventOut) else $error("trigger no event");
  a_pause_then_strobe: assert property ($rose(cpuPause) |-> ##[1:12] captureStrobe) else $error("no capture");
  a_strobe_in_pause: assert property (captureStrobe |-> cpuPause ##1 !captureStrobe) else $error("bad strobe");
  a_pause_resumes: assert property (captureStrobe |-> ##[1:3] !cpuPause) else $error("no resume");
  a_clksel_reset: assert property (s_axi_awvalid && s_axi_awready && s_axi_awaddr[7:0] == 8'h9c |-> ##[1:4] cpuReset)
    else $error("no cpu reset");
  a_reset_length: assert property ($rose(cpuReset) |-> cpuReset[*8]) else $error("cpu reset short");
endmodule : betu_checker

bind betu_bus_event_trigger_unit betu_checker u_chk (.*);

// [betu_cpu_model.sv]
/*
  betu_cpu_model: emulation cpu bus cycles and execute strobes.
  shares clk with the unit; holds off for up to 100 cycles while the cpu is paused or reset.
*/
`timescale 1ns/1ps
module betu_cpu_model (
  input wire logic clk,
  input wire logic cpuPause,
  input wire logic cpuReset,
  output betu_pkg::betu_cycle_s cpuCycle,
  output logic execValid,
  output logic [15:0] execAddr
);
  initial
  begin
    cpuCycle = '0;
    execValid = 1'b0;
    execAddr = 16'h0;
  end
  // a held cpu issues nothing for up to 100 cycles
  task automatic hold();
    int i;
    for (i = 0; i < 100 && (cpuPause || cpuReset); i++)
      @(posedge clk);
  endtask : hold
  task automatic cyc(logic [15:0] a, logic [15:0] d, logic f, logic w, logic m);
    hold();
    @(posedge clk);
    cpuCycle <= '{1'b1, a, d, f, w, m};
    @(posedge clk);
    cpuCycle <= '{1'b0, ~a, ~d, 1'b0, 1'b0, 1'b0};
  endtask : cyc
  // callers space execute addresses apart
  task automatic exe(logic [15:0] a);
    hold();
    @(posedge clk);
    execValid <= 1'b1;
    execAddr <= a;
    @(posedge clk);
    execValid <= 1'b0;
    execAddr <= ~a;
  endtask : exe
endmodule : betu_cpu_model

// [betu_bus_event_trigger_unit_tb_top.sv]
/*
  betu_bus_event_trigger_unit_tb_top: random and corner tests of the unit.
  assumes the cpu model on the bus side and axi on clk.
*/
`timescale 1ns/1ps
module betu_bus_event_trigger_unit_tb_top;
  logic clk;
  logic arst_n = 1'b0;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0, s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [7:0] senseIn = 8'h0a;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, trigOut, cpuPause, captureStrobe;
  logic cpuReset, clkSelUser, execValid;
  logic [1:0] s_axi_bresp, s_axi_rresp, captureKind;
  logic [8:0] eventOut;
  logic [15:0] execAddr;
  betu_pkg::betu_cycle_s cpuCycle;
  logic [31:0] cfg [4][5];
  int failCount = 0, samplesChecked = 0;
  betu_bus_event_trigger_unit u_dut (.*);
  betu_cpu_model mdl (.*);
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic finalReport();
    $display("checks %0d mismatches %0d", samplesChecked, failCount);
    if (failCount == 0 && samplesChecked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : finalReport
  task automatic tmo(logic t);
    if (t)
    begin
      failCount++;
      finalReport();
    end
  endtask : tmo
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    samplesChecked++;
    if (g !== e)
    begin
      failCount++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic axw(logic [7:0] a, logic [31:0] d, output logic [1:0] r);
    int i;
    logic aw, w, b;
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (i = 0; i < 40; i++)
    begin
      @(negedge clk);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge clk);
      if (aw)
        s_axi_awvalid <= 1'b0;
      if (w)
        s_axi_wvalid <= 1'b0;
      if (b)
        break;
    end
    tmo(i == 40);
  endtask : axw
  task automatic axr(logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int i;
    logic ar, rv;
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    for (i = 0; i < 40; i++)
    begin
      @(negedge clk);
      ar = s_axi_arvalid && s_axi_arready;
      rv = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clk);
      if (ar)
        s_axi_arvalid <= 1'b0;
      if (rv)
        break;
    end
    tmo(i == 40);
  endtask : axr
  task automatic look(logic [8:0] ee, logic et);
    logic [8:0] ev;
    logic t;
    ev = '0;
    t = 1'b0;
    repeat (3)
    begin
      #1;
      ev |= eventOut;
      t |= trigOut;
      @(posedge clk);
    end
    chk("events", ee, ev);
    chk("trigger", et, t);
  endtask : look
  function automatic logic stOk(logic [3:0] s, logic f, logic w, logic m);
    logic k;
    k = s < 4'h5 || (s < 4'h8 ? !m : m);
    case (s)
      4'h0: return 1'b1;
      4'h1: return f;
      4'h2, 4'h5, 4'h8: return !f && k;
      4'h3, 4'h6, 4'h9: return !f && !w && k;
      default: return !f && w && k;
    endcase
  endfunction : stOk
  function automatic logic [3:0] expEv(logic [15:0] a, logic [15:0] d, logic f, logic w, logic m, logic [3:0] x);
    logic [31:0] c [5];
    for (int j = 0; j < 4; j++)
    begin
      c = cfg[j];
      expEv[j] = ((!c[0][31] && !c[1][31]) || (c[0][31] && c[0][15:0] == a) || (c[1][31] && c[1][15:0] == a))
        && (!c[2][31] || (a <= 16'hfdff && ((d[7:0] ^ c[2][7:0]) & c[2][15:8]) == 8'h0))
        && stOk(c[3][3:0], f, w, m) && (!c[4][31] || ((x ^ c[4][3:0]) & c[4][7:4]) == 4'h0);
    end
  endfunction : expEv
  initial
  begin
    int b, n, k, i;
    logic [15:0] a, d;
    logic f, w, m, p;
    logic [3:0] x, e;
    logic [8:0] tsel;
    logic [1:0] r;
    logic [31:0] rd;
    void'($urandom(32'h4c7167e3));
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    axr(8'hfc, rd, r);
    chk("unmapped resp", betu_pkg::AXI_SLVERR, r);
    axw(8'ha0, 32'h1, r);
    chk("status write resp", betu_pkg::AXI_SLVERR, r);
    $display("test axi done");
    for (b = 0; b < 12; b++)
    begin
      for (n = 0; n < 4; n++)
        for (k = 0; k < 5; k++)
        begin
          cfg[n][k] = k == 3 ? $urandom % 11 : $urandom & (k == 4 ? 32'h800000ff : 32'h8000ffff);
          axw(8'(n * 32 + k * 4), cfg[n][k], r);
        end
      tsel = b % 3 == 0 ? 9'h0 : 9'($urandom);
      axw(8'h94, {23'h0, tsel}, r);
      x = 4'($urandom);
      senseIn <= {x, 4'ha};
      repeat (4) @(posedge clk);
      for (i = 0; i < 16; i++)
      begin
        n = $urandom % 4;
        case ($urandom % 4)
          0: a = cfg[n][0][15:0];
          1: a = cfg[n][1][15:0];
          2: a = 16'hfe00 | 16'($urandom % 512);
          default: a = 16'($urandom);
        endcase
        d = 16'($urandom);
        if ($urandom % 2)
          d[7:0] = cfg[n][2][7:0];
        f = $urandom % 4 == 0;
        w = !f && $urandom % 2;
        m = !f && $urandom % 2;
        mdl.cyc(a, d, f, w, m);
        e = expEv(a, d, f, w, m, x);
        look({5'h0, e}, |(e & tsel[3:0]));
      end
    end
    axr(8'h94, rd, r);
    chk("trigger select", {23'h0, tsel}, rd);
    $display("test bus events done");
    axw(8'h94, 32'h1f0, r);
    for (n = 0; n < 4; n++)
      axw(8'(8'h80 + n * 4), 32'h80001000 + n * 16, r);
    for (n = 0; n < 4; n++)
    begin
      mdl.exe(16'h1000 + 16'(n * 16));
      look(9'(32'h20 << n), 1'b1);
    end
    axw(8'h90, 32'h6, r);
    senseIn <= 8'h06;
    repeat (3) @(posedge clk);
    look(9'h10, 1'b1);
    senseIn <= 8'h0a;
    repeat (4) @(posedge clk);
    $display("test exec and level done");
    axw(8'h94, 32'h0, r);
    for (k = 0; k < 3; k++)
    begin
      axw(8'h98, 32'h20 | (k << 9), r);
      mdl.exe(16'h1000);
      for (i = 0; i < 30 && captureStrobe !== 1'b1; i++)
      begin
        @(posedge clk);
        #1;
      end
      tmo(i == 30);
      chk("capture kind", k, captureKind);
      repeat (6) @(posedge clk);
    end
    axw(8'h98, 32'h0, r);
    mdl.exe(16'h1000);
    p = 1'b0;
    repeat (15)
    begin
      @(posedge clk);
      p |= cpuPause;
    end
    chk("pause after cancel", 0, p);
    $display("test checkpoint done");
    axw(8'h9c, 32'h1, r);
    for (i = 0; i < 30 && cpuReset !== 1'b1; i++)
      @(posedge clk);
    tmo(i == 30);
    chk("user clock", 1, clkSelUser);
    $display("test clock select done");
    finalReport();
  end
endmodule : betu_bus_event_trigger_unit_tb_top
